/* File: axis_supervision_pkg.sv */
// constants and types shared by the axis position supervision block
`default_nettype none
package axis_supervision_pkg;
  // register bus
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_REHOME_TOL = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_SCALE_OFFSET = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_PERIOD_RATIO = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_FIXED_PITCH = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_VAR_PITCH = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_LIMIT_STOPPED = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_LIMIT_MOVING = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_DEV_PERCENT = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_ABS_POS = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_FOLLOW_ERR = 6'h2C;
  localparam logic [ADDR_W-1:0] OFF_SAVED_POS = 6'h30;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MARK_LSB = 2;
  localparam int CTRL_ABS_SEL_BIT = 4;
  localparam int CTRL_ABS_MODULE_BIT = 5;
  // status register fields
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_NEED_HOME_BIT = 1;
  localparam int ST_REF_DONE_BIT = 2;
  localparam int ST_WARN_OFF_BIT = 3;
  // lengths in units of 0.0001 mm
  localparam logic [31:0] REHOME_TOL_RST = 32'h0000_00C8;
  localparam logic [31:0] REHOME_TOL_MIN = 32'h0000_0001;
  localparam logic [31:0] REHOME_TOL_MAX = 32'h3B9A_A2F0;
  localparam logic [31:0] LIMIT_MIN = 32'h0000_0001;
  localparam logic [31:0] LIMIT_MAX = 32'h3B9A_C9FF;
  localparam logic [31:0] LIMIT_STOPPED_RST = 32'h0000_2710;
  localparam logic [31:0] LIMIT_MOVING_RST = 32'h0004_93E0;
  localparam logic [31:0] SCALE_OFFSET_RST = 32'h0000_0000;
  localparam logic [31:0] SAVED_POS_RST = 32'h0000_0000;
  // wave counts and ratios
  localparam logic [15:0] PERIOD_RATIO_RST = 16'h0000;
  localparam logic [15:0] FIXED_PITCH_RST = 16'h03E8;
  localparam logic [15:0] VAR_PITCH_RST = 16'h03E9;
  localparam logic [6:0] DEV_PERCENT_RST = 7'h32;
  localparam logic [6:0] DEV_PERCENT_MAX = 7'h64;
  typedef enum logic [1:0] {LAG_OFF, LAG_STANDARD, LAG_LINEAR} lag_mode_t;
  typedef enum logic [1:0] {MARK_PLAIN, MARK_CODED_UP, MARK_CODED_DOWN} mark_type_t;
endpackage
`default_nettype wire

/* File: mark_link_if.sv */
// signals between the register side and the coded mark decoder
`default_nettype none
interface mark_link_if;
  import axis_supervision_pkg::*;
  logic ref_pulse;
  logic signed [31:0] enc_count;
  mark_type_t mark_type;
  logic [15:0] fixed_pitch;
  logic [15:0] var_pitch;
  logic [15:0] period_ratio;
  logic established;
  logic signed [31:0] scale_base;
  modport ctrl (output ref_pulse, enc_count, mark_type, fixed_pitch, var_pitch, period_ratio,
                input established, scale_base);
  modport dec (input ref_pulse, enc_count, mark_type, fixed_pitch, var_pitch, period_ratio,
               output established, scale_base);
endinterface
`default_nettype wire

/* File: coded_mark_decoder.sv */
// resolves scale zero from two consecutive distance-coded reference pulses
`default_nettype none
module coded_mark_decoder
  import axis_supervision_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  mark_link_if.dec link
);
  logic first_seen_reg;
  logic signed [31:0] first_count_reg;
  logic established_reg;
  logic signed [31:0] scale_base_reg;
  logic coded;
  logic [31:0] gap;
  logic [31:0] step;
  logic [15:0] ratio_eff;
  logic [63:0] mark_wide;
  logic signed [31:0] mark_pos;
  logic pair_ok;

  assign coded = (link.mark_type == MARK_CODED_UP) || (link.mark_type == MARK_CODED_DOWN);
  assign gap = (link.enc_count >= first_count_reg) ? 32'(link.enc_count - first_count_reg)
                                                   : 32'(first_count_reg - link.enc_count);
  // a gap of exactly the fixed pitch carries no code, wait for the next pair
  assign pair_ok = first_seen_reg && (gap != 32'(link.fixed_pitch));
  assign step = (gap >= 32'(link.var_pitch)) ? gap - 32'(link.var_pitch) : 32'(link.var_pitch) - gap;
  // a ratio of zero is taken as one
  assign ratio_eff = (link.period_ratio == 16'h0000) ? 16'h0001 : link.period_ratio;
  assign mark_wide = 64'(step) * 64'(link.fixed_pitch) * 64'(ratio_eff);
  assign mark_pos = (link.mark_type == MARK_CODED_DOWN) ? -$signed(mark_wide[31:0]) : $signed(mark_wide[31:0]);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_seen_reg <= 1'b0;
      first_count_reg <= 32'sh0000_0000;
      established_reg <= 1'b0;
      scale_base_reg <= 32'sh0000_0000;
    end else if (link.ref_pulse && coded) begin
      first_seen_reg <= 1'b1;
      first_count_reg <= link.enc_count;
      if (pair_ok) begin
        established_reg <= 1'b1;
        scale_base_reg <= mark_pos - link.enc_count;
      end
    end
  end

  assign link.established = established_reg;
  assign link.scale_base = scale_base_reg;

  a_pair_resolves: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    link.ref_pulse && coded && pair_ok |=> established_reg && scale_base_reg == $past(mark_pos - link.enc_count))
    else $error("coded pair did not fix scale zero");
endmodule
`default_nettype wire

/* File: coded_homing_lag_monitor.sv */
// axis position supervision: coded homing, re-home check and lag monitor
// Function
// - within re-home tolerance means no re-homing; plain incremental or unresolved coded feedback always flags re-homing
// - scale offset only for coded or absolute
// - two coded pulses fix absolute position
// - scale offset moves position to machine zero
// - period ratio used only for coded scales
// - fixed mark pitch setting, default 1000
// - variable mark pitch setting, default 1001
// - pitches in waves, used when coded
// - following error is command minus actual
// - modes off, standard, linear; standard at reset
// - off mode raises no lag fault
// - standard compares moving or stopped limit
// - linear tolerates deviation up to percentage
// - warn whenever supervision is switched off
// - limits ignored while mode is off
// - stopped limit range and default 1 mm
// - moving limit 30 mm, linear start level
// - mark type plain, increasing or decreasing
// - deviation percent 0 to 100, default 50
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`default_nettype none
module coded_homing_lag_monitor
  import axis_supervision_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [axis_supervision_pkg::ADDR_W-1:0] addr_i,
  input wire logic [axis_supervision_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [axis_supervision_pkg::DATA_W-1:0] rd_data_o,
  input wire logic signed [POS_W-1:0] cmd_pos_i,
  input wire logic signed [POS_W-1:0] enc_count_i,
  input wire logic signed [POS_W-1:0] est_lag_i,
  input wire logic reference_pulse_i,
  input wire logic moving_i,
  input wire logic ctrl_cycle_i,
  output logic lag_fault_o,
  output logic need_home_o,
  output logic lag_off_warn_o,
  output logic position_ref_o,
  output logic signed [POS_W-1:0] abs_pos_o,
  output logic signed [POS_W-1:0] follow_err_o
);
  import axis_supervision_pkg::*;

  if (POS_W != 32) begin : g_pos_w_check
    $error("position width must be 32");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] magnitude(input logic signed [31:0] v);
    magnitude = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // settings
  lag_mode_t lag_monitor_mode_reg;
  mark_type_t ref_mark_type_reg;
  logic absolute_feedback_select_reg;
  logic abs_module_present_reg;
  logic [31:0] rehome_tolerance_reg;
  logic signed [31:0] coded_scale_offset_reg;
  logic [15:0] period_ratio_reg;
  logic [15:0] fixed_mark_pitch_reg;
  logic [15:0] variable_mark_pitch_reg;
  logic [31:0] lag_limit_stopped_reg;
  logic [31:0] lag_limit_moving_reg;
  logic [6:0] lag_deviation_percent_reg;
  logic signed [31:0] saved_pos_reg;
  // state
  logic lag_fault_reg;
  logic need_home_reg;
  logic warn_reg;
  logic position_ref_reg;
  logic signed [31:0] abs_pos_reg;
  logic signed [31:0] follow_err_reg;
  logic [31:0] rd_data_reg;
  logic ref_pulse_d_reg;

  mark_link_if link ();

  coded_mark_decoder u_decoder (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .link(link)
  );

  // write decode
  wire wr_ctrl = wr_en_i && hit(addr_i, OFF_CONTROL);
  wire wr_tol = wr_en_i && hit(addr_i, OFF_REHOME_TOL);
  wire wr_offset = wr_en_i && hit(addr_i, OFF_SCALE_OFFSET);
  wire wr_ratio = wr_en_i && hit(addr_i, OFF_PERIOD_RATIO);
  wire wr_fixed = wr_en_i && hit(addr_i, OFF_FIXED_PITCH);
  wire wr_var = wr_en_i && hit(addr_i, OFF_VAR_PITCH);
  wire wr_stopped = wr_en_i && hit(addr_i, OFF_LIMIT_STOPPED);
  wire wr_moving = wr_en_i && hit(addr_i, OFF_LIMIT_MOVING);
  wire wr_pct = wr_en_i && hit(addr_i, OFF_DEV_PERCENT);
  wire wr_status = wr_en_i && hit(addr_i, OFF_STATUS);
  wire wr_saved = wr_en_i && hit(addr_i, OFF_SAVED_POS);

  // field extraction and range checks; out-of-range writes leave the value
  wire [1:0] wr_mode = wr_data_i[CTRL_MODE_LSB +: 2];
  wire [1:0] wr_mark = wr_data_i[CTRL_MARK_LSB +: 2];
  wire mode_legal = (wr_mode != 2'h3);
  wire mark_legal = (wr_mark != 2'h3);
  wire tol_legal = (wr_data_i >= REHOME_TOL_MIN) && (wr_data_i <= REHOME_TOL_MAX);
  wire limit_legal = (wr_data_i >= LIMIT_MIN) && (wr_data_i <= LIMIT_MAX);
  wire pct_legal = (wr_data_i <= 32'(DEV_PERCENT_MAX));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lag_monitor_mode_reg <= LAG_STANDARD;
      ref_mark_type_reg <= MARK_PLAIN;
      absolute_feedback_select_reg <= 1'b0;
      abs_module_present_reg <= 1'b0;
    end else if (wr_ctrl) begin
      if (mode_legal) lag_monitor_mode_reg <= lag_mode_t'(wr_mode);
      if (mark_legal) ref_mark_type_reg <= mark_type_t'(wr_mark);
      absolute_feedback_select_reg <= wr_data_i[CTRL_ABS_SEL_BIT];
      abs_module_present_reg <= wr_data_i[CTRL_ABS_MODULE_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rehome_tolerance_reg <= REHOME_TOL_RST;
      coded_scale_offset_reg <= SCALE_OFFSET_RST;
      saved_pos_reg <= SAVED_POS_RST;
    end else begin
      if (wr_tol && tol_legal) rehome_tolerance_reg <= wr_data_i;
      if (wr_offset) coded_scale_offset_reg <= $signed(wr_data_i);
      if (wr_saved) saved_pos_reg <= $signed(wr_data_i);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_ratio_reg <= PERIOD_RATIO_RST;
      fixed_mark_pitch_reg <= FIXED_PITCH_RST;
      variable_mark_pitch_reg <= VAR_PITCH_RST;
    end else begin
      if (wr_ratio) period_ratio_reg <= wr_data_i[15:0];
      if (wr_fixed) fixed_mark_pitch_reg <= wr_data_i[15:0];
      if (wr_var) variable_mark_pitch_reg <= wr_data_i[15:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lag_limit_stopped_reg <= LIMIT_STOPPED_RST;
      lag_limit_moving_reg <= LIMIT_MOVING_RST;
      lag_deviation_percent_reg <= DEV_PERCENT_RST;
    end else begin
      if (wr_stopped && limit_legal) lag_limit_stopped_reg <= wr_data_i;
      if (wr_moving && limit_legal) lag_limit_moving_reg <= wr_data_i;
      if (wr_pct && pct_legal) lag_deviation_percent_reg <= wr_data_i[6:0];
    end
  end

  // coded reference marks
  wire coded = (ref_mark_type_reg != MARK_PLAIN);
  wire ref_rise = reference_pulse_i && !ref_pulse_d_reg;
  assign link.ref_pulse = ref_rise;
  assign link.enc_count = enc_count_i;
  assign link.mark_type = ref_mark_type_reg;
  assign link.fixed_pitch = fixed_mark_pitch_reg;
  assign link.var_pitch = variable_mark_pitch_reg;
  assign link.period_ratio = coded ? period_ratio_reg : 16'h0000;

  // position composition
  wire absolute_src = absolute_feedback_select_reg || abs_module_present_reg;
  wire offset_used = coded || absolute_src;
  wire signed [31:0] scale_pos = (coded && link.established) ? enc_count_i + link.scale_base : enc_count_i;
  // machine zero sits at the offset measured from scale zero
  wire signed [31:0] machine_pos = offset_used ? scale_pos - coded_scale_offset_reg : scale_pos;
  wire ref_next = coded ? link.established : absolute_src;

  // re-home decision
  wire [31:0] home_diff = magnitude(machine_pos - saved_pos_reg);
  wire within_tol = (home_diff <= rehome_tolerance_reg);
  wire need_home_next = !(ref_next && within_tol);

  // following error supervision
  wire signed [31:0] fe_now = cmd_pos_i - machine_pos;
  wire [31:0] fe_mag = magnitude(fe_now);
  wire [31:0] std_limit = moving_i ? lag_limit_moving_reg : lag_limit_stopped_reg;
  wire over_std = (fe_mag > std_limit);
  wire [31:0] dev_mag = magnitude(fe_now - est_lag_i);
  wire [31:0] est_mag = magnitude(est_lag_i);
  wire [39:0] dev_scaled = 40'(dev_mag) * 40'h64;
  wire [39:0] dev_allowed = 40'(est_mag) * 40'(lag_deviation_percent_reg);
  // dynamic check only at or above the moving limit; stopped axis keeps its static limit
  wire over_lin = moving_i ? ((fe_mag >= lag_limit_moving_reg) && (dev_scaled > dev_allowed))
                           : (fe_mag > lag_limit_stopped_reg);
  wire trip_std = (lag_monitor_mode_reg == LAG_STANDARD) && over_std;
  wire trip_lin = (lag_monitor_mode_reg == LAG_LINEAR) && over_lin;
  // off mode: neither limit is looked at
  wire lag_trip = ctrl_cycle_i && (trip_std || trip_lin);
  wire fault_clear = wr_status && wr_data_i[ST_FAULT_BIT];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lag_fault_reg <= 1'b0;
      follow_err_reg <= 32'sh0000_0000;
    end else begin
      // a trip in the clearing cycle survives
      if (lag_trip) lag_fault_reg <= 1'b1;
      else if (fault_clear) lag_fault_reg <= 1'b0;
      if (ctrl_cycle_i) follow_err_reg <= fe_now;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      need_home_reg <= 1'b1;
      warn_reg <= 1'b0;
      position_ref_reg <= 1'b0;
      abs_pos_reg <= 32'sh0000_0000;
      ref_pulse_d_reg <= 1'b0;
    end else begin
      need_home_reg <= need_home_next;
      warn_reg <= (lag_monitor_mode_reg == LAG_OFF);
      position_ref_reg <= ref_next;
      abs_pos_reg <= machine_pos;
      ref_pulse_d_reg <= reference_pulse_i;
    end
  end

  // read path
  wire [31:0] ctrl_word = {26'h0, abs_module_present_reg, absolute_feedback_select_reg,
                           ref_mark_type_reg, lag_monitor_mode_reg};
  wire [31:0] status_word = {28'h0, warn_reg, position_ref_reg, need_home_reg, lag_fault_reg};
  wire [31:0] rd_mux =
    hit(addr_i, OFF_CONTROL) ? ctrl_word :
    hit(addr_i, OFF_REHOME_TOL) ? rehome_tolerance_reg :
    hit(addr_i, OFF_SCALE_OFFSET) ? 32'(coded_scale_offset_reg) :
    hit(addr_i, OFF_PERIOD_RATIO) ? {16'h0, period_ratio_reg} :
    hit(addr_i, OFF_FIXED_PITCH) ? {16'h0, fixed_mark_pitch_reg} :
    hit(addr_i, OFF_VAR_PITCH) ? {16'h0, variable_mark_pitch_reg} :
    hit(addr_i, OFF_LIMIT_STOPPED) ? lag_limit_stopped_reg :
    hit(addr_i, OFF_LIMIT_MOVING) ? lag_limit_moving_reg :
    hit(addr_i, OFF_DEV_PERCENT) ? {25'h0, lag_deviation_percent_reg} :
    hit(addr_i, OFF_STATUS) ? status_word :
    hit(addr_i, OFF_ABS_POS) ? 32'(abs_pos_reg) :
    hit(addr_i, OFF_FOLLOW_ERR) ? 32'(follow_err_reg) :
    hit(addr_i, OFF_SAVED_POS) ? 32'(saved_pos_reg) : 32'h0000_0000;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rd_data_reg <= 32'h0000_0000;
    else rd_data_reg <= rd_en_i ? rd_mux : 32'h0000_0000;
  end

  assign rd_data_o = rd_data_reg;
  assign lag_fault_o = lag_fault_reg;
  assign need_home_o = need_home_reg;
  assign lag_off_warn_o = warn_reg;
  assign position_ref_o = position_ref_reg;
  assign abs_pos_o = abs_pos_reg;
  assign follow_err_o = follow_err_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cycle_std_over;
    ctrl_cycle_i && lag_monitor_mode_reg == LAG_STANDARD && fe_mag > std_limit;
  endsequence

  sequence s_fault_held;
    lag_fault_o ##1 (lag_fault_o || $past(fault_clear));
  endsequence

  a_rehome_within: assert property (ref_next && home_diff <= rehome_tolerance_reg |=> !need_home_o)
    else $error("re-home flagged inside tolerance");
  a_rehome_outside: assert property (home_diff > rehome_tolerance_reg |=> need_home_o)
    else $error("re-home not flagged outside tolerance");
  a_offset_gate: assert property (!coded && !absolute_src |=> abs_pos_o == $past(enc_count_i))
    else $error("offset applied to plain incremental feedback");
  a_offset_apply: assert property (absolute_src && !coded
    |=> abs_pos_o == $past(enc_count_i) - $past(coded_scale_offset_reg))
    else $error("machine zero offset not applied");
  a_fe_sample: assert property (ctrl_cycle_i |=> follow_err_o == $past(cmd_pos_i) - $past(machine_pos))
    else $error("following error not command minus actual");
  a_off_no_fault: assert property (lag_monitor_mode_reg == LAG_OFF && !lag_fault_o |=> !lag_fault_o)
    else $error("fault raised while supervision off");
  a_std_trip: assert property (s_cycle_std_over ##0 !wr_ctrl |=> s_fault_held)
    else $error("standard limit excess not flagged");
  a_lin_trip: assert property (ctrl_cycle_i && trip_lin |=> lag_fault_o)
    else $error("linear deviation excess not flagged");
  a_warn_off: assert property (lag_monitor_mode_reg == LAG_OFF |=> lag_off_warn_o)
    else $error("no warning while supervision off");
  a_warn_clear: assert property (lag_monitor_mode_reg != LAG_OFF |=> !lag_off_warn_o)
    else $error("warning while supervision on");
  a_limit_range: assert property (lag_limit_stopped_reg >= LIMIT_MIN && lag_limit_stopped_reg <= LIMIT_MAX
    && lag_limit_moving_reg >= LIMIT_MIN)
    else $error("lag limit left its range");
  a_pct_range: assert property (lag_deviation_percent_reg <= DEV_PERCENT_MAX)
    else $error("deviation percentage above 100");
  a_read_latency: assert property (rd_en_i && hit(addr_i, OFF_STATUS) |=> rd_data_o == $past(status_word))
    else $error("status read data wrong");

  // settings and position checks
  sequence s_coded_ready;
    coded && link.established;
  endsequence

  a_mode_legal: assert property (2'(lag_monitor_mode_reg) != 2'h3)
    else $error("lag mode holds an unused code");
  a_mark_legal: assert property (2'(ref_mark_type_reg) != 2'h3)
    else $error("mark type holds an unused code");
  a_ratio_gate: assert property (!coded |-> link.period_ratio == 16'h0000)
    else $error("period ratio used on plain scale");
  a_pitch_hold: assert property (!wr_fixed && !wr_var |=> $stable(fixed_mark_pitch_reg) && $stable(variable_mark_pitch_reg))
    else $error("mark pitch changed without a write");
  a_off_ignore: assert property (lag_monitor_mode_reg == LAG_OFF |-> !lag_trip)
    else $error("limit looked at while supervision off");
  a_lin_start: assert property (lag_monitor_mode_reg == LAG_LINEAR && moving_i && fe_mag < lag_limit_moving_reg |-> !trip_lin)
    else $error("dynamic check below its start level");
  a_fe_hold: assert property (!ctrl_cycle_i |=> follow_err_o == $past(follow_err_o))
    else $error("following error updated outside a control cycle");
  a_module_offset: assert property (abs_module_present_reg && !coded
    |=> abs_pos_o == $past(enc_count_i) - $past(coded_scale_offset_reg))
    else $error("offset not applied with absolute module");
  a_coded_base: assert property (s_coded_ready
    |=> abs_pos_o == $past(enc_count_i) + $past(link.scale_base) - $past(coded_scale_offset_reg))
    else $error("coded position not referred to machine zero");
  a_ref_hold: assert property (s_coded_ready |=> position_ref_o)
    else $error("established position not reported");
  a_fault_clear: assert property (fault_clear && !lag_trip |=> !lag_fault_o)
    else $error("fault not cleared by status write");
  a_fault_quiet: assert property (!lag_fault_o && !lag_trip |=> !lag_fault_o)
    else $error("fault raised without a trip");
  a_pct_refuse: assert property (wr_pct && !pct_legal |=> $stable(lag_deviation_percent_reg))
    else $error("out of range percentage taken");
  a_tol_refuse: assert property (wr_tol && !tol_legal |=> $stable(rehome_tolerance_reg))
    else $error("out of range tolerance taken");
endmodule
`default_nettype wire

/* File: coded_scale_model.sv */
// behavioural distance-coded scale: incremental count plus two reference marks
`default_nettype none
module coded_scale_model #(
  parameter logic signed [31:0] MARK_A = 32'sh0000_1388,
  parameter logic signed [31:0] MARK_B = 32'sh0000_1772
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic signed [31:0] step_i,
  input wire logic load_i,
  input wire logic signed [31:0] load_val_i,
  output logic signed [31:0] enc_count_o,
  output logic reference_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] count_next;
  assign count_next = load_i ? load_val_i : enc_count_o + step_i;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enc_count_o <= 32'sh0000_0000;
      reference_pulse_o <= 1'b0;
    end else begin
      enc_count_o <= count_next;
      // one-cycle pulse only while travelling over a mark
      reference_pulse_o <= !load_i && step_i != 0 && (count_next == MARK_A || count_next == MARK_B);
    end
  end
endmodule
`default_nettype wire

/* File: tb_coded_homing_lag_monitor.sv */
// self-checking bench for the axis position supervision block
`default_nettype none
module tb_coded_homing_lag_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import axis_supervision_pkg::*;
  typedef struct {logic [5:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, wr_en = 1'b0, rd_en = 1'b0, moving = 1'b0, ctrl_cycle = 1'b0;
  logic load = 1'b0, ref_pulse, lag_fault, need_home, warn, pos_ref;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, v, m;
  logic signed [31:0] cmd_pos = 32'sh0, est_lag = 32'sh0, step = 32'sh0, load_val = 32'sh0;
  logic signed [31:0] enc, abs_pos, follow_err;
  int mismatches = 0, n_tests = 0, i;
  row_t rows[28] = '{
    '{6'h00, 1'b0, 32'h0, 32'h0000_0001}, '{6'h04, 1'b0, 32'h0, 32'h0000_00C8},
    '{6'h08, 1'b0, 32'h0, 32'h0000_0000}, '{6'h0C, 1'b0, 32'h0, 32'h0000_0000},
    '{6'h10, 1'b0, 32'h0, 32'h0000_03E8}, '{6'h14, 1'b0, 32'h0, 32'h0000_03E9},
    '{6'h18, 1'b0, 32'h0, 32'h0000_2710}, '{6'h1C, 1'b0, 32'h0, 32'h0004_93E0},
    '{6'h20, 1'b0, 32'h0, 32'h0000_0032}, '{6'h3C, 1'b0, 32'h0, 32'h0000_0000},
    '{6'h00, 1'b1, 32'h0000_0003, 32'h0000_0001}, '{6'h00, 1'b1, 32'h0000_0009, 32'h0000_0009},
    '{6'h00, 1'b1, 32'h0000_000D, 32'h0000_0009}, '{6'h00, 1'b1, 32'h0000_0001, 32'h0000_0001},
    '{6'h20, 1'b1, 32'h0000_0065, 32'h0000_0032}, '{6'h20, 1'b1, 32'h0000_0064, 32'h0000_0064},
    '{6'h20, 1'b1, 32'h0000_0032, 32'h0000_0032}, '{6'h18, 1'b1, 32'h0000_0000, 32'h0000_2710},
    '{6'h1C, 1'b1, 32'h3B9A_CA00, 32'h0004_93E0}, '{6'h0C, 1'b1, 32'h0000_FFFF, 32'h0000_FFFF},
    '{6'h0C, 1'b1, 32'h0000_0000, 32'h0000_0000}, '{6'h10, 1'b1, 32'h0000_FFFF, 32'h0000_FFFF},
    '{6'h10, 1'b1, 32'h0000_03E8, 32'h0000_03E8}, '{6'h2C, 1'b1, 32'h0000_FFFF, 32'h0000_0000},
    '{6'h3C, 1'b1, 32'h0000_00FF, 32'h0000_0000}, '{6'h04, 1'b1, 32'h3B9A_A2F0, 32'h3B9A_A2F0},
    '{6'h04, 1'b1, 32'h3B9A_A2F1, 32'h3B9A_A2F0}, '{6'h04, 1'b1, 32'h0000_00C8, 32'h0000_00C8}};

  always #12.5 sys_clk_i = ~sys_clk_i;

  coded_scale_model scale (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .step_i(step), .load_i(load),
    .load_val_i(load_val), .enc_count_o(enc), .reference_pulse_o(ref_pulse));
  coded_homing_lag_monitor #(.POS_W(32)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata), .cmd_pos_i(cmd_pos),
    .enc_count_i(enc), .est_lag_i(est_lag), .reference_pulse_i(ref_pulse), .moving_i(moving),
    .ctrl_cycle_i(ctrl_cycle), .lag_fault_o(lag_fault), .need_home_o(need_home), .lag_off_warn_o(warn),
    .position_ref_o(pos_ref), .abs_pos_o(abs_pos), .follow_err_o(follow_err));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_i);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk_i);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic lag(input logic [31:0] c, input logic mv, input logic [31:0] e, input logic f);
    wr(OFF_STATUS, 32'h0000_0001);
    cmd_pos <= c;
    moving <= mv;
    est_lag <= e;
    @(posedge sys_clk_i);
    ctrl_cycle <= 1'b1;
    @(posedge sys_clk_i);
    ctrl_cycle <= 1'b0;
    #1 chk("lag_fault", {31'h0, lag_fault}, {31'h0, f});
    chk("follow_err", follow_err, c);
  endtask
  task automatic home(input logic [31:0] c);
    wr(OFF_CONTROL, c);
    load_val <= 32'sh0000_137E;
    load <= 1'b1;
    cyc(1);
    load <= 1'b0;
    step <= 32'sh0000_0001;
    #1 chk("ref_early", {31'h0, pos_ref}, 32'h0);
    for (i = 0; i < 2000 && pos_ref !== 1'b1; i++) cyc(1);
    step <= 32'sh0000_0000;
    if (i == 2000) chk("ref_wait", 32'h0, 32'h1);
    cyc(3);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    cyc(3);
    #1 chk("need_home_rst", {31'h0, need_home}, 32'h1);
    chk("flags_rst", {29'h0, lag_fault, warn, pos_ref}, 32'h0);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 28; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("register", v, rows[i].e);
    end
    lag(32'h0000_2710, 1'b0, 32'h0, 1'b0);
    lag(32'h0000_2711, 1'b0, 32'h0, 1'b1);
    lag(32'h0000_0000, 1'b0, 32'h0, 1'b0);
    lag(32'hFFFF_D8EF, 1'b0, 32'h0, 1'b1);
    lag(32'h0004_93E0, 1'b1, 32'h0, 1'b0);
    lag(32'hFFFB_6C1F, 1'b1, 32'h0, 1'b1);
    wr(OFF_CONTROL, 32'h0000_0002);
    lag(32'h0004_93E0, 1'b1, 32'h0003_0D40, 1'b0);
    lag(32'h0004_93E0, 1'b1, 32'h0003_0D3F, 1'b1);
    lag(32'h0004_93DF, 1'b1, 32'h0000_0000, 1'b0);
    lag(32'h0000_2711, 1'b0, 32'h0, 1'b1);
    wr(OFF_CONTROL, 32'h0000_0000);
    cyc(2);
    chk("warn_off", {31'h0, warn}, 32'h1);
    lag(32'h7FFF_FFFF, 1'b1, 32'h0, 1'b0);
    lag(32'h0000_4E20, 1'b0, 32'h0, 1'b0);
    wr(OFF_CONTROL, 32'h0000_0001);
    wr(OFF_SCALE_OFFSET, 32'h0000_0064);
    load_val <= 32'sh0000_0309;
    load <= 1'b1;
    cyc(1);
    load <= 1'b0;
    cyc(3);
    chk("warn_on", {31'h0, warn}, 32'h0);
    chk("abs_plain", abs_pos, 32'h0000_0309);
    wr(OFF_CONTROL, 32'h0000_0011);
    cyc(2);
    chk("abs_select", abs_pos, 32'h0000_02A5);
    wr(OFF_CONTROL, 32'h0000_0021);
    cyc(2);
    chk("abs_module", abs_pos, 32'h0000_02A5);
    home(32'h0000_0005);
    m = enc - 32'sh0000_13EE;
    chk("abs_coded", abs_pos, m);
    wr(OFF_SAVED_POS, m + 32'h0000_00C8);
    cyc(2);
    chk("home_edge", {31'h0, need_home}, 32'h0);
    wr(OFF_SAVED_POS, m + 32'h0000_00C9);
    cyc(2);
    chk("home_far", {31'h0, need_home}, 32'h1);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    cyc(2);
    #1 chk("rst_mid", {29'h0, need_home, pos_ref, lag_fault}, 32'h0000_0004);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    home(32'h0000_0009);
    chk("abs_down", abs_pos, enc - 32'sh0000_1B5A);
    conclude();
  end
endmodule
`default_nettype wire
